// ### core/pllcrf_defines.vh
// Constants for the synthesizer serial register front end
`ifndef PLLCRF_DEFINES_VH
`define PLLCRF_DEFINES_VH

// Frame layout: 24 data bits, 5 address bits, 3 chip bits
`define PLLCRF_FRAME_BITS     6'd32
`define PLLCRF_DATA_W         24
`define PLLCRF_ADDR_W         5
`define PLLCRF_CHIP_W         3
`define PLLCRF_DATA_MSB       31
`define PLLCRF_DATA_LSB       8
`define PLLCRF_ADDR_MSB       7
`define PLLCRF_ADDR_LSB       3
`define PLLCRF_CHIP_MSB       2
`define PLLCRF_CHIP_LSB       0
`define PLLCRF_CHIP_ADDR      3'h0

// Register addresses
`define PLLCRF_REG_ID         5'h00
`define PLLCRF_REG_PWR        5'h01
`define PLLCRF_REG_RDIV       5'h02

// Identity value, arbitrary neutral code
`define PLLCRF_ID_VALUE       24'h5A5A01

// Read pointer and soft reset fields
`define PLLCRF_PTR_MSB        4
`define PLLCRF_PTR_LSB        0
`define PLLCRF_SRST_BIT       5

// Power enable register
`define PLLCRF_PWR_W          10
`define PLLCRF_PWR_RESET      10'h003
`define PLLCRF_PWR_PINSEL     0
`define PLLCRF_PWR_SPIEN      1
`define PLLCRF_PWR_BIAS       2
`define PLLCRF_PWR_DET        3
`define PLLCRF_PWR_PUMP       4
`define PLLCRF_PWR_REFBUF     5
`define PLLCRF_PWR_OSC        6
`define PLLCRF_PWR_DRV        7

// Reference divider register
`define PLLCRF_RDIV_W         14
`define PLLCRF_RDIV_RESET     14'h0001

`endif

// ### core/pllcrf_sync.v
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module pllcrf_sync (
    input  wire i_sys_clk,
    input  wire i_rst_b,
    input  wire i_async,
    output wire o_sync
);
    reg meta_q;
    reg sync_q;

    // First stage feeds only the second stage
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule
`default_nettype wire

// ### core/pllcrf_edge.v
// Rising and falling edge detector on a synchronised level
`timescale 1ns/1ps
`default_nettype none
module pllcrf_edge (
    input  wire i_sys_clk,
    input  wire i_rst_b,
    input  wire i_level,
    output wire o_rise,
    output wire o_fall
);
    reg last_q;

    // Remember previous level
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            last_q <= 1'b0;
        end else begin
            last_q <= i_level;
        end
    end

    assign o_rise = i_level & ~last_q;
    assign o_fall = ~i_level & last_q;
endmodule
`default_nettype wire

// ### core/pllcrf_top.v
// Serial register front end: identity, read pointer, power enable, reference divider
//
// Contract
// - Address zero reads a fixed 24-bit identity; writes never change it.
// - Write to address zero stores bits 4:0 as next read-back address.
// - Bit 5 of an address zero write is a soft reset strobe.
// - Pin select set: low enable pin means power-down.
// - Pin select clear: enable pin ignored, register bit rules.
// - Register control: serial enable bit 1 enables, 0 disables.
// - Bias keep-on bit holds bias generators active during power-down.
// - Phase detector keep-on bit keeps detector powered always.
// - Charge pump keep-on bit keeps charge pump powered always.
// - Reference buffer keep-on bit keeps buffer powered always.
// - Oscillator keep-on bit keeps oscillator core powered always.
// - Output driver keep-on bit keeps output driver active always.
// - Power register resets to pin control, serial enable set, rest clear.
// - Reference divider holds 14-bit ratio; host uses 1 to 16383.
// - Reference divider resets to one.
// - Frame is 24 data, 5 address, 3 chip bits, MSB first.
// - Addressed register updates on latch rising edge after 32 clocks.
// - Read takes two frames; second shifts out addressed register.
`timescale 1ns/1ps
`default_nettype none
`include "pllcrf_defines.vh"
module pllcrf_top (
    input  wire                        i_sys_clk,
    input  wire                        i_rst_b,
    input  wire                        i_serial_clk,
    input  wire                        i_serial_data_in,
    input  wire                        i_serial_latch_enable,
    input  wire                        i_chip_enable_pin,
    input  wire                        i_lock_detect,
    output reg                         o_lock_or_serial_out,
    output wire                        o_chip_enabled,
    output wire                        o_bias_on,
    output wire                        o_phase_detector_on,
    output wire                        o_charge_pump_on,
    output wire                        o_ref_buffer_on,
    output wire                        o_oscillator_core_on,
    output wire                        o_general_purpose_output_on,
    output wire [`PLLCRF_RDIV_W-1:0]   o_ref_divide_ratio,
    output wire [`PLLCRF_PWR_W-1:0]    o_power_control
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and edge finders
    wire sclk_s;
    wire sdat_s;
    wire slat_s;
    wire pin_s;
    wire lock_s;
    wire sclk_rise;
    wire sclk_fall;
    wire slat_rise;
    wire slat_fall_unused;

    pllcrf_sync u_sync_sclk (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_async   (i_serial_clk),
        .o_sync    (sclk_s)
    );
    pllcrf_sync u_sync_sdat (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_async   (i_serial_data_in),
        .o_sync    (sdat_s)
    );
    pllcrf_sync u_sync_slat (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_async   (i_serial_latch_enable),
        .o_sync    (slat_s)
    );
    pllcrf_sync u_sync_pin (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_async   (i_chip_enable_pin),
        .o_sync    (pin_s)
    );
    pllcrf_sync u_sync_lock (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_async   (i_lock_detect),
        .o_sync    (lock_s)
    );

    pllcrf_edge u_edge_sclk (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_level   (sclk_s),
        .o_rise    (sclk_rise),
        .o_fall    (sclk_fall)
    );
    pllcrf_edge u_edge_slat (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_level   (slat_s),
        .o_rise    (slat_rise),
        .o_fall    (slat_fall_unused)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    reg  [`PLLCRF_PTR_MSB:0]       rd_ptr_q;
    reg  [`PLLCRF_PWR_W-1:0]       pwr_q;
    reg  [`PLLCRF_RDIV_W-1:0]      rdiv_q;
    reg  [`PLLCRF_FRAME_BITS-1:0]  shift_q;
    reg  [5:0]                     bit_cnt_q;
    reg  [`PLLCRF_DATA_W-1:0]      out_q;
    reg                            reading_q;

    wire [`PLLCRF_DATA_W-1:0] frame_data = shift_q[`PLLCRF_DATA_MSB:`PLLCRF_DATA_LSB];
    wire [`PLLCRF_ADDR_W-1:0] frame_addr = shift_q[`PLLCRF_ADDR_MSB:`PLLCRF_ADDR_LSB];
    wire [`PLLCRF_CHIP_W-1:0] frame_chip = shift_q[`PLLCRF_CHIP_MSB:`PLLCRF_CHIP_LSB];

    // Latch accepted only for a complete frame to this chip
    wire latch_ok = slat_rise && (bit_cnt_q == `PLLCRF_FRAME_BITS)
                  && (frame_chip == `PLLCRF_CHIP_ADDR);
    wire wr_ptr   = latch_ok && (frame_addr == `PLLCRF_REG_ID);
    wire soft_rst = wr_ptr && frame_data[`PLLCRF_SRST_BIT];

    // Read-back mux; identity is a constant so writes cannot alter it
    reg [`PLLCRF_DATA_W-1:0] rd_data;
    always @* begin
        case (rd_ptr_q)
            `PLLCRF_REG_ID:   rd_data = `PLLCRF_ID_VALUE;
            `PLLCRF_REG_PWR:  rd_data = {14'h0000, pwr_q};
            `PLLCRF_REG_RDIV: rd_data = {10'h000, rdiv_q};
            default:          rd_data = 24'h000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial shifter: sample data on each serial clock rise, MSB first
    // Counter saturates past a frame so overlong frames are rejected
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shift_q   <= 32'h00000000;
            bit_cnt_q <= 6'h00;
        end else if (slat_rise) begin
            bit_cnt_q <= 6'h00;
        end else if (sclk_rise) begin
            shift_q   <= {shift_q[`PLLCRF_FRAME_BITS-2:0], sdat_s};
            if (bit_cnt_q != 6'h3F) begin
                bit_cnt_q <= bit_cnt_q + 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register update on latch edge; soft reset wins over the written data
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_ptr_q <= `PLLCRF_REG_ID;
            pwr_q    <= `PLLCRF_PWR_RESET;
            rdiv_q   <= `PLLCRF_RDIV_RESET;
        end else if (soft_rst) begin
            rd_ptr_q <= `PLLCRF_REG_ID;
            pwr_q    <= `PLLCRF_PWR_RESET;
            rdiv_q   <= `PLLCRF_RDIV_RESET;
        end else if (latch_ok) begin
            case (frame_addr)
                `PLLCRF_REG_ID: begin
                    rd_ptr_q <= frame_data[`PLLCRF_PTR_MSB:`PLLCRF_PTR_LSB];
                end
                `PLLCRF_REG_PWR: begin
                    pwr_q <= frame_data[`PLLCRF_PWR_W-1:0];
                end
                `PLLCRF_REG_RDIV: begin
                    rdiv_q <= frame_data[`PLLCRF_RDIV_W-1:0];
                end
                default: begin
                    rd_ptr_q <= rd_ptr_q;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read-back shifter: loaded at frame start, MSB out on first serial rise
    // Out data changes after each rise; host samples it on the next rise
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_q     <= 24'h000000;
            reading_q <= 1'b0;
        end else if (slat_rise) begin
            reading_q <= 1'b0;
        end else if (sclk_rise) begin
            if (bit_cnt_q == 6'h00) begin
                out_q     <= {rd_data[`PLLCRF_DATA_W-2:0], 1'b0};
                reading_q <= 1'b1;
            end else begin
                out_q <= {out_q[`PLLCRF_DATA_W-2:0], 1'b0};
            end
        end
    end

    // Serial out pin: data bit while reading, lock detect otherwise
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_lock_or_serial_out <= 1'b0;
        end else if (slat_rise) begin
            o_lock_or_serial_out <= lock_s;
        end else if (sclk_rise && bit_cnt_q == 6'h00) begin
            o_lock_or_serial_out <= rd_data[`PLLCRF_DATA_W-1];
        end else if (sclk_rise && reading_q) begin
            o_lock_or_serial_out <= out_q[`PLLCRF_DATA_W-1];
        end else if (!reading_q) begin
            o_lock_or_serial_out <= lock_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power control; reserved bits 9:8 drive only o_power_control and the read-back data
    wire chip_en = pwr_q[`PLLCRF_PWR_PINSEL] ? pin_s
                                             : pwr_q[`PLLCRF_PWR_SPIEN];

    assign o_chip_enabled              = chip_en;
    assign o_bias_on                   = chip_en | pwr_q[`PLLCRF_PWR_BIAS];
    assign o_phase_detector_on         = chip_en | pwr_q[`PLLCRF_PWR_DET];
    assign o_charge_pump_on            = chip_en | pwr_q[`PLLCRF_PWR_PUMP];
    assign o_ref_buffer_on             = chip_en | pwr_q[`PLLCRF_PWR_REFBUF];
    assign o_oscillator_core_on        = chip_en | pwr_q[`PLLCRF_PWR_OSC];
    assign o_general_purpose_output_on = chip_en | pwr_q[`PLLCRF_PWR_DRV];
    assign o_ref_divide_ratio          = rdiv_q;
    assign o_power_control             = pwr_q;

endmodule
`default_nettype wire

// ### sim/pllcrf_props.sv
// Port-level checks for the serial register front end
`timescale 1ns/1ps
`default_nettype none
module pllcrf_props (
    input wire logic        i_sys_clk,
    input wire logic        i_rst_b,
    input wire logic        i_serial_latch_enable,
    input wire logic        i_chip_enable_pin,
    input wire logic        o_chip_enabled,
    input wire logic        o_bias_on,
    input wire logic        o_phase_detector_on,
    input wire logic        o_charge_pump_on,
    input wire logic        o_ref_buffer_on,
    input wire logic        o_oscillator_core_on,
    input wire logic        o_general_purpose_output_on,
    input wire logic [13:0] o_ref_divide_ratio,
    input wire logic [9:0]  o_power_control
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    wire [9:0] p = o_power_control;
    wire       en = o_chip_enabled;
    ////////////////////////////////////////////////////////////////
    // Enable source selection; pin path needs time to synchronise
    sel_reg_a: assert property (!p[0] |-> en == p[1])
        else $error("register enable mismatch");
    pin_off_a: assert property ((p[0] && !i_chip_enable_pin)[*4] |-> !en)
        else $error("pin low did not power down");
    // Keep-on bits override a power-down
    bias_keep_a: assert property (o_bias_on == (en || p[2]))
        else $error("bias output wrong");
    det_keep_a: assert property (o_phase_detector_on == (en || p[3]))
        else $error("phase detector output wrong");
    pump_keep_a: assert property (o_charge_pump_on == (en || p[4]))
        else $error("charge pump output wrong");
    ref_keep_a: assert property (o_ref_buffer_on == (en || p[5]))
        else $error("reference buffer output wrong");
    osc_keep_a: assert property (o_oscillator_core_on == (en || p[6]))
        else $error("oscillator output wrong");
    drv_keep_a: assert property (o_general_purpose_output_on == (en || p[7]))
        else $error("output driver wrong");
    // Reset values seen right after release
    rst_vals_a: assert property ($rose(i_rst_b) |-> p == 10'h003 && o_ref_divide_ratio == 14'h0001)
        else $error("reset values wrong");
    // Registers only move a few cycles after a latch rise
    latch_commit_a: assert property (($changed(o_ref_divide_ratio) || $changed(p)) |-> $past(i_serial_latch_enable, 3))
        else $error("register changed without latch");
    cover property (!p[0] && en);
    cover property (o_bias_on && !en);
    cover property ($changed(o_ref_divide_ratio));
endmodule
bind pllcrf_top pllcrf_props u_props (.i_sys_clk, .i_rst_b, .i_serial_latch_enable,
    .i_chip_enable_pin, .o_chip_enabled, .o_bias_on, .o_phase_detector_on, .o_charge_pump_on,
    .o_ref_buffer_on, .o_oscillator_core_on, .o_general_purpose_output_on,
    .o_ref_divide_ratio, .o_power_control);
`default_nettype wire

// ### sim/pllcrf_host.sv
// Host serial master model: sends frames, captures read data
`timescale 1ns/1ps
`default_nettype none
module pllcrf_host (
    output var logic o_ser_clk,
    output var logic o_ser_data,
    output var logic o_latch,
    input  wire logic i_ser_out
);
    // Link parked: clock low between frames
    initial begin
        o_ser_clk = 1'b0;
        o_ser_data = 1'b0;
        o_latch = 1'b0;
    end
    // One frame, MSB first, data moved on falling edges only
    task frame(input logic [31:0] f, output logic [23:0] rd);
        integer i;
        begin
            rd = 24'h0;
            for (i = 31; i >= 0; i--) begin
                o_ser_clk = 1'b0;
                o_ser_data = f[i];
                #80 o_ser_clk = 1'b1;
                if (i <= 30 && i >= 7) rd[i-7] = i_ser_out;
                #80;
            end
            o_ser_clk = 1'b0;
            o_ser_data = ~o_ser_data; // Released line shows no stale value
            #80 o_latch = 1'b1;
            #80 o_latch = 1'b0;
            #80;
        end
    endtask
endmodule
`default_nettype wire

// ### sim/test_pll_control_register_front.sv
// Testbench for the serial register front end
`timescale 1ns/1ps
`default_nettype none
`include "pllcrf_defines.vh"
module test_pll_control_register_front;
    logic        i_sys_clk, i_rst_b, pin, lock;
    wire         sclk, sdat, slat, sout, en, bias, det, pump, refb, osc, drv;
    wire  [13:0] rdiv;
    wire  [9:0]  pwr;
    wire  [6:0]  pw = {en, bias, det, pump, refb, osc, drv};
    logic [23:0] rd;
    int          num_errors = 0, checked = 0, cycles = 0, i;
    pllcrf_host u_host (.o_ser_clk(sclk), .o_ser_data(sdat), .o_latch(slat), .i_ser_out(sout));
    pllcrf_top u_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_serial_clk(sclk),
        .i_serial_data_in(sdat), .i_serial_latch_enable(slat), .i_chip_enable_pin(pin),
        .i_lock_detect(lock), .o_lock_or_serial_out(sout), .o_chip_enabled(en),
        .o_bias_on(bias), .o_phase_detector_on(det), .o_charge_pump_on(pump),
        .o_ref_buffer_on(refb), .o_oscillator_core_on(osc),
        .o_general_purpose_output_on(drv), .o_ref_divide_ratio(rdiv), .o_power_control(pwr));
    ////////////////////////////////////////////////////////////////
    // Clock and hang guard; a full run needs about 10000 cycles
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            wrap_up;
        end
    end
    task chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task setin(input logic p, input logic l);
        @(posedge i_sys_clk);
        #1 pin = p;
        lock = l;
        repeat (5) @(posedge i_sys_clk);
    endtask
    // Register write; settle time covers the synchroniser lag
    task wr(input logic [4:0] a, input logic [23:0] d);
        #1 u_host.frame({d, a, 3'h0}, rd);
        repeat (8) @(posedge i_sys_clk);
    endtask
    task rdback(input logic [4:0] a, input logic [23:0] exp);
        wr(5'h00, {19'h0, a});
        wr(5'h00, {19'h0, a});
        chk(rd, exp);
    endtask
    task t_reset;
        chk(pwr, 24'h3);
        chk(rdiv, 24'h1);
        rdback(5'h00, `PLLCRF_ID_VALUE);
    endtask
    task t_rdiv;
        wr(5'h02, 24'h003FFF);
        chk(rdiv, 24'h3FFF);
        rdback(5'h02, 24'h003FFF);
        #1 u_host.frame({24'h000005, 5'h02, 3'h1}, rd);
        repeat (8) @(posedge i_sys_clk);
        chk(rdiv, 24'h3FFF);
    endtask
    // Each keep-on bit alone while register control holds power-down
    task t_power;
        setin(1'b0, 1'b0);
        for (i = 2; i <= 7; i++) begin
            wr(5'h01, 24'h1 << i);
            chk(pw, 24'h40 >> (i - 1));
        end
        wr(5'h01, 24'h000300);
        chk(pw, 24'h0);
        rdback(5'h01, 24'h000300);
        wr(5'h01, 24'h000002);
        chk(pw, 24'h7F);
        wr(5'h01, 24'h000001);
        chk(pw, 24'h0);
        setin(1'b1, 1'b0);
        chk(pw, 24'h7F);
    endtask
    task t_soft;
        wr(5'h01, 24'h000000);
        wr(5'h00, 24'h000020);
        chk(pwr, 24'h3);
        chk(rdiv, 24'h1);
        setin(1'b1, 1'b1);
        chk(sout, 24'h1);
        setin(1'b1, 1'b0);
        chk(sout, 24'h0);
    endtask
    task wrap_up;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        i_rst_b = 1'b0;
        pin = 1'b1;
        lock = 1'b0;
        repeat (20) @(posedge i_sys_clk);
        #1 i_rst_b = 1'b1;
        repeat (4) @(posedge i_sys_clk);
        t_reset;
        t_rdiv;
        t_power;
        t_soft;
        wrap_up;
    end
endmodule
`default_nettype wire
